// File: smc_pkg.sv
// smc_pkg: constants and carrier types for the synthesizer/modulator configuration block.
// assumes a single 200 MHz system clock domain; no imports anywhere.
package smc_pkg;
    localparam int          WORD_W       = 24;
    localparam int          NUM_REGS     = 8;
    localparam int          ADDR_LSB     = 0;
    localparam int          ADDR_W       = 3;
    // per-register indices
    localparam logic [2:0]  IDX_INT      = 3'h0;
    localparam logic [2:0]  IDX_MOD      = 3'h1;
    localparam logic [2:0]  IDX_FRAC     = 3'h2;
    localparam logic [2:0]  IDX_DITHER   = 3'h3;
    localparam logic [2:0]  IDX_CP_REF   = 3'h4;
    localparam logic [2:0]  IDX_LO_MOD   = 3'h5;
    localparam logic [2:0]  IDX_VCO      = 3'h6;
    localparam logic [2:0]  IDX_EXT_VCO  = 3'h7;
    // reset values of the control words
    localparam logic [23:0] RST_INT      = 24'h0001c0;
    localparam logic [23:0] RST_MOD      = 24'h003001;
    localparam logic [23:0] RST_FRAC     = 24'h001802;
    localparam logic [23:0] RST_OTHER    = 24'h000000;
    // synthesizer enable field in the VCO word
    localparam int          SYN_EN_LSB   = 17;
    localparam int          SYN_EN_MSB   = 20;
    // fields in the LO path word (own layout); the last one sits in the external vco word
    localparam int          LO_EN_BIT    = 3;
    localparam int          LO_MULT_LSB  = 4;
    localparam int          RF_EN_BIT    = 6;
    localparam int          EXT_LO_BIT   = 7;
    localparam int          EXT_VCO_BIT  = 3;
    // lo multiplier codes
    localparam logic [1:0]  LO_X1        = 2'h0;
    localparam logic [1:0]  LO_X2        = 2'h1;
    localparam logic [1:0]  LO_X4        = 2'h2;
    // axi4-lite map (byte addresses) and response codes
    localparam logic [7:0]  A_WORD_BASE  = 8'h00;
    localparam logic [7:0]  A_STATUS     = 8'h20;
    localparam logic [7:0]  A_CTRL       = 8'h24;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef struct packed {
        logic        lo_drive_en;
        logic [1:0]  lo_mult;
        logic        ext_lo_in;
        logic        synth_on;
        logic        ext_vco;
        logic        rf_en;
    } smc_lo_ctl_t;
endpackage : smc_pkg

// File: smc_serial_rx.sv
// smc_serial_rx: three-wire word receiver, msb first, load strobe ends the word.
// assumes the serial pins are synchronous to sys_clk and slower than it.
`timescale 1ns/100ps
module smc_serial_rx #(
    parameter int WORD_W = 24
) (
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    input  wire logic              ser_clk,
    input  wire logic              ser_data,
    input  wire logic              ser_load,
    output logic [WORD_W-1:0]      word,
    output logic                   word_valid
);
    logic [WORD_W-1:0] shift_reg;
    logic              clk_d_reg;
    logic              load_d_reg;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            clk_d_reg  <= 1'b0;
            load_d_reg <= 1'b0;
        end else begin
            clk_d_reg  <= ser_clk;
            load_d_reg <= ser_load;
        end
    end

    // shift on the rising serial clock, msb enters first
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            shift_reg <= '0;
        end else if (ser_clk && !clk_d_reg && !ser_load) begin
            shift_reg <= {shift_reg[WORD_W-2:0], ser_data};
        end
    end

    // rising load edge presents the captured word for one cycle
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            word       <= '0;
            word_valid <= 1'b0;
        end else begin
            word_valid <= ser_load && !load_d_reg;
            if (ser_load && !load_d_reg) begin
                word <= shift_reg;
            end
        end
    end
endmodule : smc_serial_rx

// File: smc_config_regs.sv
// smc_config_regs: configuration register bank of the modulator/synthesizer.
// assumes a host driving the three-wire port and software on axi4-lite.
`timescale 1ns/100ps
module smc_config_regs #(
    parameter int WORD_W   = smc_pkg::WORD_W,
    parameter int NUM_REGS = smc_pkg::NUM_REGS
) (
    input  wire logic                sys_clk,
    input  wire logic                resetn,
    input  wire logic                ser_clk,
    input  wire logic                ser_data,
    input  wire logic                ser_load,
    input  wire logic                lo_output_select,
    output logic                     lo_port_out_en_n,
    output logic                     lo_port_in_en,
    output smc_pkg::smc_lo_ctl_t     lo_ctl,
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready
);
    logic [WORD_W-1:0]   cfg_reg [NUM_REGS];
    logic [WORD_W-1:0]   rx_word;
    logic                rx_valid;
    logic [NUM_REGS-1:0] written_reg;
    logic                order_err_reg;
    logic [2:0]          expect_reg;
    logic                lo_lock_reg;
    logic [7:0]          aw_reg;
    logic                aw_have_reg;
    logic [31:0]         w_reg;
    logic                w_have_reg;
    logic                w_strb0_reg;
    logic [2:0]          dst;
    smc_pkg::smc_lo_ctl_t lo_next;

    smc_serial_rx #(.WORD_W(WORD_W)) u_rx (
        .sys_clk    (sys_clk),
        .resetn     (resetn),
        .ser_clk    (ser_clk),
        .ser_data   (ser_data),
        .ser_load   (ser_load),
        .word       (rx_word),
        .word_valid (rx_valid)
    );

    function automatic logic [WORD_W-1:0] rst_val(input int idx);
        case (idx)
            0:       rst_val = smc_pkg::RST_INT;
            1:       rst_val = smc_pkg::RST_MOD;
            2:       rst_val = smc_pkg::RST_FRAC;
            default: rst_val = smc_pkg::RST_OTHER;
        endcase
    endfunction : rst_val

    assign dst = rx_word[smc_pkg::ADDR_LSB +: smc_pkg::ADDR_W];

    // word lands where its own address bits point, function fixed by index
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                cfg_reg[i] <= rst_val(i);
            end
        end else if (rx_valid) begin
            cfg_reg[dst] <= rx_word;
        end
    end

    // track the start-up sequence; the host owns the ordering, we only report
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            written_reg   <= '0;
            expect_reg    <= smc_pkg::IDX_EXT_VCO;
            order_err_reg <= 1'b0;
        end else if (rx_valid) begin
            written_reg[dst] <= 1'b1;
            if (!(&written_reg)) begin
                if (dst != expect_reg) begin
                    order_err_reg <= 1'b1;
                end
                expect_reg <= expect_reg - 3'h1;
            end // once all written, no check
        end
    end

    // derive lo routing from the lo path, vco and external vco words
    always_comb begin
        lo_next.rf_en      = cfg_reg[smc_pkg::IDX_LO_MOD][smc_pkg::RF_EN_BIT];
        lo_next.lo_mult    = cfg_reg[smc_pkg::IDX_LO_MOD][smc_pkg::LO_MULT_LSB +: 2];
        lo_next.ext_lo_in  = cfg_reg[smc_pkg::IDX_LO_MOD][smc_pkg::EXT_LO_BIT];
        lo_next.ext_vco    = cfg_reg[smc_pkg::IDX_EXT_VCO][smc_pkg::EXT_VCO_BIT];
        lo_next.synth_on   =
            |cfg_reg[smc_pkg::IDX_VCO][smc_pkg::SYN_EN_MSB:smc_pkg::SYN_EN_LSB];
        // a reserved multiplier code is treated as not driving
        lo_next.lo_drive_en = lo_output_select && lo_next.rf_en && !lo_next.ext_lo_in
            && cfg_reg[smc_pkg::IDX_LO_MOD][smc_pkg::LO_EN_BIT]
            && (lo_next.lo_mult != 2'h3) && (&written_reg);
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            lo_ctl           <= '0;
            lo_port_out_en_n <= 1'b1;
            lo_port_in_en    <= 1'b0;
        end else begin
            lo_ctl           <= lo_next;
            lo_port_out_en_n <= !(lo_next.lo_drive_en && !lo_lock_reg);
            lo_port_in_en    <= lo_next.ext_lo_in || !lo_next.synth_on;
        end
    end

    // axi write: address and data taken in either order, response after both
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            aw_reg        <= '0;
            w_reg         <= '0;
            w_strb0_reg   <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= smc_pkg::RESP_OKAY;
            lo_lock_reg   <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_reg && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_have_reg && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                aw_reg      <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                w_reg      <= s_axi_wdata;
                // strobe is only valid with its data beat, so keep it with the data
                w_strb0_reg <= s_axi_wstrb[0];
            end
            if (aw_have_reg && w_have_reg && !s_axi_bvalid) begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_reg == smc_pkg::A_CTRL) begin
                    s_axi_bresp <= smc_pkg::RESP_OKAY;
                    if (w_strb0_reg) begin
                        lo_lock_reg <= w_reg[0];
                    end
                end else begin
                    s_axi_bresp <= smc_pkg::RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi read: config words read back, status and control
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= smc_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= smc_pkg::RESP_OKAY;
                if (s_axi_araddr < smc_pkg::A_STATUS && s_axi_araddr[1:0] == 2'h0) begin
                    s_axi_rdata <= {8'h00, cfg_reg[s_axi_araddr[4:2]]};
                end else if (s_axi_araddr == smc_pkg::A_STATUS) begin
                    s_axi_rdata <= {20'h00000, lo_ctl.synth_on, !lo_port_out_en_n,
                                    order_err_reg, &written_reg, written_reg};
                end else if (s_axi_araddr == smc_pkg::A_CTRL) begin
                    s_axi_rdata <= {31'h00000000, lo_lock_reg};
                end else begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= smc_pkg::RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : smc_config_regs

// File: smc_config_regs_sva.sv
// smc_config_regs_sva: port-level checks of the configuration bank.
// assumes it is bound to smc_config_regs; one clock, synchronous reset.
`timescale 1ns/100ps
module smc_config_regs_sva (
    input wire logic                 sys_clk,
    input wire logic                 resetn,
    input wire logic                 ser_load,
    input wire logic                 lo_output_select,
    input wire logic                 lo_port_out_en_n,
    input wire logic                 lo_port_in_en,
    input wire smc_pkg::smc_lo_ctl_t lo_ctl,
    input wire logic                 s_axi_awready,
    input wire logic                 s_axi_arvalid,
    input wire logic                 s_axi_arready,
    input wire logic [31:0]          s_axi_rdata,
    input wire logic                 s_axi_rvalid,
    input wire logic                 s_axi_rready
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    property p_rf_off_lo_off; !lo_ctl.rf_en |-> lo_port_out_en_n; endproperty
    a_rf_off_lo_off: assert property (p_rf_off_lo_off) else $error("lo driven, rf off");
    property p_drive_cause; !lo_port_out_en_n |-> $past(lo_output_select) && !lo_ctl.ext_lo_in;
    endproperty
    a_drive_cause: assert property (p_drive_cause) else $error("lo driven w/o cause");
    property p_in_cause; lo_port_in_en |-> lo_ctl.ext_lo_in || !lo_ctl.synth_on; endproperty
    a_in_cause: assert property (p_in_cause) else $error("lo input w/o cause");
    property p_drive_flag; lo_ctl.lo_drive_en |-> $past(lo_output_select) && lo_ctl.rf_en
        && !lo_ctl.ext_lo_in; endproperty
    a_drive_flag: assert property (p_drive_flag) else $error("drive flag w/o cause");
    // serial fields move only after a load strobe, never while bits shift in
    property p_quiet; (!ser_load)[*4] ##0 $past(resetn, 4) |-> $stable({lo_ctl.lo_mult,
        lo_ctl.ext_lo_in, lo_ctl.synth_on, lo_ctl.ext_vco, lo_ctl.rf_en}); endproperty
    a_quiet: assert property (p_quiet) else $error("config moved w/o load");
    property p_ar_to_r; s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid; endproperty
    a_ar_to_r: assert property (p_ar_to_r) else $error("read answer late");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data not held");
    property p_aw_pulse; s_axi_awready |=> !s_axi_awready; endproperty
    a_aw_pulse: assert property (p_aw_pulse) else $error("awready not a pulse");
    property p_ar_pulse; s_axi_arready |=> !s_axi_arready; endproperty
    a_ar_pulse: assert property (p_ar_pulse) else $error("arready not a pulse");
endmodule : smc_config_regs_sva

// File: smc_host_model.sv
// smc_host_model: host side of the three-wire port.
// assumes send is called just after a sys_clk edge.
`timescale 1ns/100ps
module smc_host_model (
    input wire logic sys_clk,
    output logic     ser_clk,
    output logic     ser_data,
    output logic     ser_load
);
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_load = 1'b0;
    end
    // random half period so both prompt and slow hosts are seen
    task automatic send(input logic [23:0] w);
        int h;
        for (int i = 23; i >= 0; i--) begin
            h = 2 + $urandom_range(2);
            ser_data <= w[i];
            @(posedge sys_clk);
            ser_clk <= 1'b1;
            repeat (h) @(posedge sys_clk);
            ser_clk <= 1'b0;
            repeat (h) @(posedge sys_clk);
        end
        // data no longer valid: flip it so a stale bit cannot pass
        ser_data <= ~w[0];
        ser_load <= 1'b1;
        repeat (2) @(posedge sys_clk);
        ser_load <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask : send
endmodule : smc_host_model

// File: tb_top.sv
// tb_top: self-checking bench for smc_config_regs.
// assumes smc_pkg, the host model and the checker are compiled first.
`timescale 1ns/100ps
module tb_top;
    logic sys_clk, resetn, lo_output_select, lo_port_out_en_n, lo_port_in_en;
    logic ser_clk, ser_data, ser_load, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    smc_pkg::smc_lo_ctl_t lo_ctl;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, r;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [23:0] words [8];
    logic [1:0] mults [3];
    int errors, total_checks;

    smc_config_regs i_smc_config_regs (.sys_clk, .resetn, .ser_clk, .ser_data, .ser_load,
        .lo_output_select, .lo_port_out_en_n, .lo_port_in_en, .lo_ctl, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    smc_host_model u_host (.sys_clk, .ser_clk, .ser_data, .ser_load);

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok, w_ok;
        @(posedge sys_clk);
        {aw_ok, w_ok} = '0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            aw_ok = aw_ok | (s_axi_awready & s_axi_awvalid);
            w_ok = w_ok | (s_axi_wready & s_axi_wvalid);
            s_axi_awvalid <= !aw_ok;
            s_axi_wvalid <= !w_ok;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata & m, e);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask : axi_rd

    function automatic logic [23:0] lo_word(input logic [1:0] m, input logic rf, ext);
        return {16'h0, ext, rf, m, 1'b1, smc_pkg::IDX_LO_MOD};
    endfunction : lo_word

    // expected: {out_en_n, in_en, mult, synth_on, ext_vco}
    task automatic lo_case(input logic sel, input logic [23:0] w, input logic [5:0] e);
        lo_output_select <= sel;
        u_host.send(w);
        chk({26'h0, lo_port_out_en_n, lo_port_in_en, lo_ctl.lo_mult, lo_ctl.synth_on,
             lo_ctl.ext_vco}, {26'h0, e});
    endtask : lo_case

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    initial begin
        {errors, total_checks} = '0;
        {resetn, lo_output_select, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        mults = '{smc_pkg::LO_X1, smc_pkg::LO_X2, smc_pkg::LO_X4};
        r = $urandom(46067);
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        axi_rd(smc_pkg::A_STATUS, 32'h3ff, 32'h0, smc_pkg::RESP_OKAY);
        chk({31'h0, lo_port_out_en_n}, 32'h1);
        for (int i = 7; i >= 0; i--) begin
            r = $urandom();
            words[i] = {r[20:0], 3'(i)};
            u_host.send(words[i]);
        end
        for (int i = 0; i < 8; i++) begin
            axi_rd(smc_pkg::A_WORD_BASE + 8'(4 * i), 32'hffffffff, {8'h0, words[i]},
                   smc_pkg::RESP_OKAY);
        end
        axi_rd(smc_pkg::A_STATUS, 32'h3ff, 32'h1ff, smc_pkg::RESP_OKAY);
        axi_wr(smc_pkg::A_WORD_BASE + 8'h04, r, smc_pkg::RESP_SLVERR);
        axi_rd(8'h80, 32'hffffffff, 32'h0, smc_pkg::RESP_SLVERR);
        $display("test load done");
        u_host.send({3'h0, 4'hf, 14'h0, smc_pkg::IDX_VCO});
        u_host.send({20'h0, 1'b1, smc_pkg::IDX_EXT_VCO});
        for (int k = 0; k < 3; k++) begin
            lo_case(1'b1, lo_word(mults[k], 1'b1, 1'b0), {2'b00, mults[k], 2'b11});
        end
        lo_case(1'b1, lo_word(mults[1], 1'b0, 1'b0), {2'b10, mults[1], 2'b11});
        lo_case(1'b1, lo_word(mults[1], 1'b1, 1'b1), {2'b11, mults[1], 2'b11});
        lo_case(1'b0, lo_word(mults[1], 1'b1, 1'b0), {2'b10, mults[1], 2'b11});
        lo_case(1'b1, {21'h0, smc_pkg::IDX_VCO}, {2'b01, mults[1], 2'b01});
        axi_wr(smc_pkg::A_CTRL, 32'h1, smc_pkg::RESP_OKAY);
        axi_rd(smc_pkg::A_STATUS, 32'h600, 32'h0, smc_pkg::RESP_OKAY);
        chk({31'h0, lo_port_out_en_n}, 32'h1);
        $display("test lo done");
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        u_host.send({21'h0, smc_pkg::IDX_INT});
        axi_rd(smc_pkg::A_STATUS, 32'h3ff, 32'h201, smc_pkg::RESP_OKAY);
        axi_rd(smc_pkg::A_WORD_BASE + 8'h04, 32'hffffffff, {8'h0, smc_pkg::RST_MOD},
               smc_pkg::RESP_OKAY);
        axi_rd(smc_pkg::A_WORD_BASE + 8'h08, 32'hffffffff, {8'h0, smc_pkg::RST_FRAC},
               smc_pkg::RESP_OKAY);
        $display("test order done");
        give_verdict();
    end

    // whole run is about 3200 cycles
    initial begin
        repeat (30000) @(posedge sys_clk);
        errors++;
        give_verdict();
    end
endmodule : tb_top

bind smc_config_regs smc_config_regs_sva u_sva (.sys_clk, .resetn, .ser_load, .lo_output_select,
    .lo_port_out_en_n, .lo_port_in_en, .lo_ctl, .s_axi_awready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
